/* File: design/pgdp_defs.vh */
`ifndef PGDP_DEFS_VH
`define PGDP_DEFS_VH
// ---------------------------------------------
// index port and register indices
// ---------------------------------------------
`define PGDP_IDX_FILL_VALUE 4'h0
`define PGDP_IDX_FILL_ENABLE 4'h1
`define PGDP_IDX_MATCH_VALUE 4'h2
`define PGDP_IDX_ROTATE_FUNC 4'h3
`define PGDP_IDX_READ_PLANE 4'h4
`define PGDP_IDX_MODE 4'h5
`define PGDP_IDX_WINDOW_MISC 4'h6
`define PGDP_IDX_PLANE_IGNORE 4'h7
`define PGDP_IDX_BIT_MASK 4'h8
`define PGDP_IDX_W 4
// ---------------------------------------------
// field positions
// ---------------------------------------------
`define PGDP_MODE_WMODE 1:0
`define PGDP_MODE_TEST 2
`define PGDP_MODE_READ 3
`define PGDP_MODE_ODDEVEN 4
`define PGDP_MODE_SHIFTREG 5
`define PGDP_MODE_SHIFT256 6
`define PGDP_MISC_GFX 0
`define PGDP_MISC_CHAIN 1
`define PGDP_MISC_MAP 3:2
`define PGDP_ROT_COUNT 2:0
`define PGDP_ROT_FUNC 4:3
`define PGDP_NIB 3:0
`define PGDP_SEL 1:0
// ---------------------------------------------
// encodings
// ---------------------------------------------
`define PGDP_WM0 2'h0
`define PGDP_WM1 2'h1
`define PGDP_WM2 2'h2
`define PGDP_WM3 2'h3
`define PGDP_FN_NONE 2'h0
`define PGDP_FN_AND 2'h1
`define PGDP_FN_OR 2'h2
`define PGDP_FN_XOR 2'h3
`define PGDP_MAP_128K 2'h0
`define PGDP_MAP_64K 2'h1
`define PGDP_MAP_32K_LO 2'h2
`define PGDP_MAP_32K_HI 2'h3
// window bases as paragraph addresses, host address bits 19:15
`define PGDP_SEG_A000 5'h14
`define PGDP_SEG_B000 5'h16
`define PGDP_SEG_B800 5'h17
// 128K window: host address bits 19:17
`define PGDP_SEG_128K 3'h5
// plane pairs picked by A0: planes 1 and 3, or planes 0 and 2
`define PGDP_PAIR_ODD 4'hA
`define PGDP_PAIR_EVEN 4'h5
`define PGDP_ROT_ALL 4:0
`define PGDP_MODE_KEEP 6:0
`define PGDP_SEG_A_HI 4'hA
`define PGDP_ZERO8 8'h00
`define PGDP_ONES8 8'hFF
`define PGDP_ZERO4 4'h0
`endif

/* File: design/pgdp_rotator.v */
`timescale 1ns/1ps
`include "pgdp_defs.vh"
// rotate a byte right by a 0..7 count
module pgdp_rotator (
  dataIn,
  count,
  dataOut
);
  input wire [7:0] dataIn;
  input wire [2:0] count;
  output wire [7:0] dataOut;
  wire [15:0] doubled;
  wire [15:0] shifted;
  assign doubled = {dataIn, dataIn};
  assign shifted = doubled >> count;
  assign dataOut = shifted[7:0];
endmodule

/* File: design/pgdp_plane_alu.v */
`timescale 1ns/1ps
`include "pgdp_defs.vh"
// one plane's write path: source select, logic function, bit mask
module pgdp_plane_alu (
  writeMode,
  func,
  rotData,
  hostBit,
  fillBit,
  fillEn,
  latch,
  mask,
  result
);
  input wire [1:0] writeMode;
  input wire [1:0] func;
  input wire [7:0] rotData;
  input wire hostBit;
  input wire fillBit;
  input wire fillEn;
  input wire [7:0] latch;
  input wire [7:0] mask;
  output reg [7:0] result;
  reg [7:0] src;
  reg [7:0] op;
  reg [7:0] effMask;
  always @* begin
    src = rotData;
    effMask = mask;
    case (writeMode)
      `PGDP_WM0: begin
        if (fillEn) begin
          src = {8{fillBit}};
        end else begin
          src = rotData;
        end
      end
      `PGDP_WM2: begin
        src = {8{hostBit}};
      end
      `PGDP_WM3: begin
        src = {8{fillBit}};
        effMask = rotData & mask;
      end
      default: begin
        src = latch;
        effMask = `PGDP_ZERO8;
      end
    endcase
    case (func)
      `PGDP_FN_AND: op = src & latch;
      `PGDP_FN_OR: op = src | latch;
      `PGDP_FN_XOR: op = src ^ latch;
      default: op = src;
    endcase
    // masked bits keep the latched byte, unmasked take the processed data
    result = (op & effMask) | (latch & ~effMask);
  end
endmodule

/* File: design/pgdp_datapath.v */
`timescale 1ns/1ps
`include "pgdp_defs.vh"
module pgdp_datapath #(
  parameter ADDR_W = 16
) (
  clk_sys,
  resetn,
  ioWrite,
  ioRead,
  ioIsData,
  ioWData,
  ioRData,
  hostAddr,
  memWrite,
  memRead,
  hostWData,
  hostRData,
  windowHit,
  planeAddr,
  planeWriteEnable,
  fourPlaneChaining,
  planeRData,
  planeWData,
  planeSelect,
  planeWrite,
  graphicsMode,
  charLatchEnable,
  oddEvenMode,
  shiftInterleave,
  shift256
);
  input wire clk_sys;
  input wire resetn;
  input wire ioWrite;
  input wire ioRead;
  input wire ioIsData;
  input wire [7:0] ioWData;
  output reg [7:0] ioRData;
  input wire [19:0] hostAddr;
  input wire memWrite;
  input wire memRead;
  input wire [7:0] hostWData;
  output reg [7:0] hostRData;
  output reg windowHit;
  output reg [ADDR_W-1:0] planeAddr;
  input wire [3:0] planeWriteEnable;
  input wire fourPlaneChaining;
  input wire [31:0] planeRData;
  output reg [31:0] planeWData;
  output reg [3:0] planeSelect;
  output reg planeWrite;
  output wire graphicsMode;
  output wire charLatchEnable;
  output wire oddEvenMode;
  output wire shiftInterleave;
  output wire shift256;

  // ---------------------------------------------
  // register file
  // ---------------------------------------------
  reg [3:0] datapathIndex;
  reg [3:0] planeFillValue;
  reg [3:0] planeFillEnable;
  reg [3:0] colourMatchValue;
  reg [4:0] rotateAndFunction;
  reg [1:0] readPlaneSelect;
  reg [7:0] datapathMode;
  reg [3:0] memoryWindowMisc;
  reg [3:0] comparePlaneIgnore;
  reg [7:0] writeBitMask;
  reg [31:0] latches;

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      datapathIndex <= `PGDP_ZERO4;
      planeFillValue <= `PGDP_ZERO4;
      planeFillEnable <= `PGDP_ZERO4;
      colourMatchValue <= `PGDP_ZERO4;
      rotateAndFunction <= 5'h00;
      readPlaneSelect <= 2'h0;
      datapathMode <= `PGDP_ZERO8;
      memoryWindowMisc <= `PGDP_ZERO4;
      comparePlaneIgnore <= `PGDP_ZERO4;
      writeBitMask <= `PGDP_ONES8;
    end else if (ioWrite) begin
      if (!ioIsData) begin
        datapathIndex <= ioWData[`PGDP_NIB];
      end else begin
        case (datapathIndex)
          `PGDP_IDX_FILL_VALUE: planeFillValue <= ioWData[`PGDP_NIB];
          `PGDP_IDX_FILL_ENABLE: planeFillEnable <= ioWData[`PGDP_NIB];
          `PGDP_IDX_MATCH_VALUE: colourMatchValue <= ioWData[`PGDP_NIB];
          `PGDP_IDX_ROTATE_FUNC: rotateAndFunction <= ioWData[`PGDP_ROT_ALL];
          `PGDP_IDX_READ_PLANE: readPlaneSelect <= ioWData[`PGDP_SEL];
          // bit 2 is stored so software reads it back, but nothing looks at it
          `PGDP_IDX_MODE: datapathMode <= {1'b0, ioWData[`PGDP_MODE_KEEP]};
          `PGDP_IDX_WINDOW_MISC: memoryWindowMisc <= ioWData[`PGDP_NIB];
          `PGDP_IDX_PLANE_IGNORE: comparePlaneIgnore <= ioWData[`PGDP_NIB];
          `PGDP_IDX_BIT_MASK: writeBitMask <= ioWData;
          default: datapathIndex <= datapathIndex;
        endcase
      end
    end
  end

  always @* begin
    ioRData = `PGDP_ZERO8;
    if (!ioIsData) begin
      ioRData = {4'h0, datapathIndex};
    end else begin
      case (datapathIndex)
        `PGDP_IDX_FILL_VALUE: ioRData = {4'h0, planeFillValue};
        `PGDP_IDX_FILL_ENABLE: ioRData = {4'h0, planeFillEnable};
        `PGDP_IDX_MATCH_VALUE: ioRData = {4'h0, colourMatchValue};
        `PGDP_IDX_ROTATE_FUNC: ioRData = {3'h0, rotateAndFunction};
        `PGDP_IDX_READ_PLANE: ioRData = {6'h00, readPlaneSelect};
        `PGDP_IDX_MODE: ioRData = datapathMode;
        `PGDP_IDX_WINDOW_MISC: ioRData = {4'h0, memoryWindowMisc};
        `PGDP_IDX_PLANE_IGNORE: ioRData = {4'h0, comparePlaneIgnore};
        `PGDP_IDX_BIT_MASK: ioRData = writeBitMask;
        default: ioRData = `PGDP_ZERO8;
      endcase
    end
  end

  // ---------------------------------------------
  // mode decode
  // ---------------------------------------------
  wire [1:0] writeMode;
  wire readCompare;
  wire chainOddEven;
  assign writeMode = datapathMode[`PGDP_MODE_WMODE];
  assign readCompare = datapathMode[`PGDP_MODE_READ];
  assign oddEvenMode = datapathMode[`PGDP_MODE_ODDEVEN];
  assign shiftInterleave = datapathMode[`PGDP_MODE_SHIFTREG];
  assign shift256 = datapathMode[`PGDP_MODE_SHIFT256];
  assign graphicsMode = memoryWindowMisc[`PGDP_MISC_GFX];
  assign charLatchEnable = ~memoryWindowMisc[`PGDP_MISC_GFX];
  assign chainOddEven = memoryWindowMisc[`PGDP_MISC_CHAIN];

  // ---------------------------------------------
  // window decode and address mapping
  // ---------------------------------------------
  reg hit;
  reg [16:0] offs;
  always @* begin
    hit = 1'b0;
    offs = 17'h00000;
    case (memoryWindowMisc[`PGDP_MISC_MAP])
      `PGDP_MAP_128K: begin
        hit = (hostAddr[19:17] == `PGDP_SEG_128K);
        offs = hostAddr[16:0];
      end
      `PGDP_MAP_64K: begin
        hit = (hostAddr[19:16] == `PGDP_SEG_A_HI);
        offs = {1'b0, hostAddr[15:0]};
      end
      `PGDP_MAP_32K_LO: begin
        hit = (hostAddr[19:15] == `PGDP_SEG_B000);
        offs = {2'h0, hostAddr[14:0]};
      end
      default: begin
        hit = (hostAddr[19:15] == `PGDP_SEG_B800);
        offs = {2'h0, hostAddr[14:0]};
      end
    endcase
  end

  // chain and odd/even both steer A0 to a plane pair; A0 is replaced by a high bit
  wire pairMode;
  wire [ADDR_W-1:0] linearAddr;
  wire [ADDR_W-1:0] chainAddr;
  wire [3:0] pairPlanes;
  assign pairMode = chainOddEven | oddEvenMode;
  assign linearAddr = offs[ADDR_W-1:0];
  assign chainAddr = {offs[ADDR_W-1:1], offs[16]};
  assign pairPlanes = offs[0] ? `PGDP_PAIR_ODD : `PGDP_PAIR_EVEN;

  // ---------------------------------------------
  // write path
  // ---------------------------------------------
  wire [7:0] rotData;
  wire [31:0] aluOut;
  pgdp_rotator uRot (
    .dataIn(hostWData),
    .count(rotateAndFunction[`PGDP_ROT_COUNT]),
    .dataOut(rotData)
  );
  genvar p;
  generate
    for (p = 0; p < 4; p = p + 1) begin : gPlane
      pgdp_plane_alu uAlu (
        .writeMode(writeMode),
        .func(rotateAndFunction[`PGDP_ROT_FUNC]),
        .rotData(rotData),
        .hostBit(hostWData[p]),
        .fillBit(planeFillValue[p]),
        .fillEn(planeFillEnable[p]),
        .latch(latches[8*p+7:8*p]),
        .mask(writeBitMask),
        .result(aluOut[8*p+7:8*p])
      );
    end
  endgenerate

  // ---------------------------------------------
  // read path
  // ---------------------------------------------
  wire [7:0] cmpOut;
  reg [7:0] planeByte;
  genvar cb;
  generate
    for (cb = 0; cb < 8; cb = cb + 1) begin : gCmp
      wire [3:0] column;
      wire [3:0] mismatch;
      assign column = {planeRData[24+cb], planeRData[16+cb], planeRData[8+cb], planeRData[cb]};
      // a plane with its bit clear is left out, so it can never spoil the match
      assign mismatch = (column ^ colourMatchValue) & comparePlaneIgnore;
      assign cmpOut[cb] = ~|mismatch;
    end
  endgenerate
  wire [1:0] readSel;
  // chaining overrides the plane select; the low address bits pick the plane
  assign readSel = fourPlaneChaining ? offs[1:0] : (pairMode ? {readPlaneSelect[1], offs[0]} : readPlaneSelect);
  always @* begin
    case (readSel)
      2'h0: planeByte = planeRData[7:0];
      2'h1: planeByte = planeRData[15:8];
      2'h2: planeByte = planeRData[23:16];
      default: planeByte = planeRData[31:24];
    endcase
  end

  // ---------------------------------------------
  // host memory cycle, one clock; read data returned next clock
  // ---------------------------------------------
  reg rdPending;
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      latches <= 32'h00000000;
      hostRData <= `PGDP_ZERO8;
      rdPending <= 1'b0;
    end else begin
      rdPending <= memRead & hit;
      if (rdPending) begin
        latches <= planeRData;
        hostRData <= readCompare ? cmpOut : planeByte;
      end
    end
  end

  always @* begin
    windowHit = hit;
    planeWrite = memWrite & hit;
    planeWData = aluOut;
    planeAddr = pairMode ? chainAddr : linearAddr;
    planeSelect = pairMode ? (pairPlanes & planeWriteEnable) : planeWriteEnable;
  end
endmodule

/* File: verif/pgdp_mem_model.sv */
`timescale 1ns/1ps
module pgdp_mem_model #(
  parameter ADDR_W = 16
) (
  input wire clk_sys,
  input wire memRead,
  input wire [ADDR_W-1:0] planeAddr,
  input wire [31:0] planeWData,
  input wire [3:0] planeSelect,
  input wire [3:0] planeWriteEnable,
  input wire planeWrite,
  output reg [31:0] planeRData
);
  reg [31:0] mem [0:255];
  integer n;
  initial planeRData = 32'h0;
  always @(posedge clk_sys) begin
    // outside a read cycle the bus never shows the last value
    planeRData <= memRead ? mem[planeAddr[7:0]] : ~planeRData;
    for (n = 0; n < 4; n = n + 1) begin
      if (planeWrite && planeSelect[n] && planeWriteEnable[n]) begin
        mem[planeAddr[7:0]][8*n +: 8] <= planeWData[8*n +: 8];
      end
    end
  end
endmodule

/* File: verif/pgdp_sva.sv */
`timescale 1ns/1ps
module pgdp_sva (
  input wire clk_sys,
  input wire resetn,
  input wire ioWrite,
  input wire ioIsData,
  input wire [7:0] ioWData,
  input wire [7:0] ioRData,
  input wire [19:0] hostAddr,
  input wire memWrite,
  input wire memRead,
  input wire [7:0] hostWData,
  input wire [7:0] hostRData,
  input wire windowHit,
  input wire fourPlaneChaining,
  input wire [31:0] planeRData,
  input wire [31:0] planeWData,
  input wire planeWrite,
  input wire graphicsMode,
  input wire charLatchEnable,
  input wire oddEvenMode
);
  reg [7:0] r [0:8];
  reg [3:0] idx;
  reg rdPend;
  reg [31:0] lat;
  integer i;
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      idx <= 4'h0;
      rdPend <= 1'b0;
      lat <= 32'h0;
      for (i = 0; i < 9; i = i + 1) r[i] <= (i == 8) ? 8'hFF : 8'h00;
    end else begin
      rdPend <= memRead && windowHit;
      if (rdPend) lat <= planeRData;
      if (ioWrite && !ioIsData) idx <= ioWData[3:0];
      if (ioWrite && ioIsData && idx < 4'h9) r[idx] <= ioWData;
    end
  end
  wire [31:0] msk = {4{r[8]}};
  wire [1:0] wm = r[5][1:0];
  wire [31:0] fill2 = {{8{hostWData[3]}}, {8{hostWData[2]}}, {8{hostWData[1]}}, {8{hostWData[0]}}};
  wire [31:0] rsh = lat >> {r[4][1:0], 3'b000};
  wire [4:0] s = hostAddr[19:15];
  wire [1:0] mp = r[6][3:2];
  wire hitx = mp == 2'h0 ? s[4:2] == 3'h5 : mp == 2'h1 ? s[4:1] == 4'hA : mp == 2'h2 ? s == 5'h16 : s == 5'h17;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  a_write_gate: assert property (planeWrite == (memWrite && windowHit))
    else $error("plane write not gated by window");
  a_window_decode: assert property (windowHit == hitx)
    else $error("window decode wrong");
  a_gfx_latch: assert property (graphicsMode == r[6][0] && charLatchEnable == !r[6][0])
    else $error("graphics or character latch wrong");
  a_oddeven_bit: assert property (oddEvenMode == r[5][4])
    else $error("odd/even output wrong");
  a_mode_readback: assert property (ioIsData && idx == 4'h5 |-> ioRData == {1'b0, r[5][6:0]})
    else $error("mode readback wrong");
  a_mask_keep: assert property (planeWrite |-> (planeWData & ~msk) == (lat & ~msk))
    else $error("masked bit not taken from latch");
  a_mode1_latch: assert property (planeWrite && wm == 2'h1 |-> planeWData == lat)
    else $error("mode 1 data not latch");
  a_mode2_fill: assert property (planeWrite && wm == 2'h2 && r[3][4:3] == 2'h0 |-> (planeWData & msk) == (fill2 & msk))
    else $error("mode 2 fill wrong");
  a_read_plane: assert property (rdPend && !r[5][3] && !r[5][4] && !r[6][1] && !fourPlaneChaining |=> hostRData == rsh[7:0])
    else $error("plane read data wrong");
  a_read_hold: assert property (!rdPend |=> $stable(hostRData))
    else $error("read data changed without read");
  cover property (planeWrite && wm == 2'h3);
  cover property (planeWrite && wm == 2'h2);
  cover property (rdPend && r[5][3]);
endmodule

/* File: verif/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  reg clk_sys, resetn, ioWrite, ioRead, ioIsData, memWrite, memRead, fourPlaneChaining;
  reg [7:0] ioWData, hostWData, d;
  reg [19:0] hostAddr;
  reg [3:0] planeWriteEnable;
  wire [7:0] ioRData, hostRData;
  wire windowHit, planeWrite;
  wire [15:0] planeAddr;
  wire [31:0] planeRData, planeWData;
  wire [3:0] planeSelect;
  reg [7:0] rg [0:8];
  reg [31:0] sh [0:15];
  reg [31:0] w, pe, t;
  integer errors, num_checks, k, i, a;
  localparam [159:0] WTAB = {20'h9FFFF, 20'hA0000, 20'hAFFFF, 20'hB0000, 20'hB7FFF, 20'hB8000, 20'hBFFFF, 20'hC0000};
  pgdp_datapath pgdp_datapath_inst (.clk_sys(clk_sys), .resetn(resetn), .ioWrite(ioWrite), .ioRead(ioRead),
    .ioIsData(ioIsData), .ioWData(ioWData), .ioRData(ioRData), .hostAddr(hostAddr), .memWrite(memWrite),
    .memRead(memRead), .hostWData(hostWData), .hostRData(hostRData), .windowHit(windowHit),
    .planeAddr(planeAddr), .planeWriteEnable(planeWriteEnable), .fourPlaneChaining(fourPlaneChaining),
    .planeRData(planeRData), .planeWData(planeWData), .planeSelect(planeSelect), .planeWrite(planeWrite),
    .graphicsMode(), .charLatchEnable(), .oddEvenMode(), .shiftInterleave(), .shift256());
  pgdp_mem_model pgdp_mem_model_inst (.clk_sys(clk_sys), .memRead(memRead), .planeAddr(planeAddr),
    .planeWData(planeWData), .planeSelect(planeSelect), .planeWriteEnable(planeWriteEnable),
    .planeWrite(planeWrite), .planeRData(planeRData));
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  task chk(input [31:0] got, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task give_verdict;
    begin
      $display("checks=%0d errors=%0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  task iow(input [3:0] x, input [7:0] v);
    begin
      @(negedge clk_sys);
      ioIsData = 1'b0;
      ioWData = {4'h0, x};
      ioWrite = 1'b1;
      @(negedge clk_sys);
      ioIsData = 1'b1;
      ioWData = v;
      @(negedge clk_sys);
      ioWrite = 1'b0;
      rg[x] = v;
      #1;
      if (x == 4'h5 || x == 4'h8) chk(ioRData, x == 4'h5 ? {1'b0, v[6:0]} : v);
    end
  endtask
  task memrd(input [19:0] ad);
    begin
      @(negedge clk_sys);
      hostAddr = ad;
      memRead = 1'b1;
      @(negedge clk_sys);
      memRead = 1'b0;
      @(negedge clk_sys);
    end
  endtask
  task memwr(input [19:0] ad, input [7:0] v, input [31:0] exp);
    begin
      @(negedge clk_sys);
      hostAddr = ad;
      hostWData = v;
      memWrite = 1'b1;
      #1 chk(planeWData, exp);
      @(negedge clk_sys);
      memWrite = 1'b0;
    end
  endtask
  function [31:0] wexp(input [31:0] l, input [7:0] v);
    reg [7:0] rd, m;
    reg [31:0] s, f;
    integer n;
    begin
      rd = (v >> rg[3][2:0]) | (v << (8 - rg[3][2:0]));
      m = rg[5][1:0] == 2'h3 ? rd & rg[8] : rg[5][1:0] == 2'h1 ? 8'h00 : rg[8];
      for (n = 0; n < 4; n = n + 1)
        s[8*n +: 8] = rg[5][1:0] == 2'h2 ? {8{v[n]}} : (rg[5][1:0] == 2'h3 || (rg[5][1:0] == 2'h0 && rg[1][n]))
          ? {8{rg[0][n]}} : rd;
      f = rg[3][4:3] == 2'h1 ? s & l : rg[3][4:3] == 2'h2 ? s | l : rg[3][4:3] == 2'h3 ? s ^ l : s;
      wexp = (f & {4{m}}) | (l & ~{4{m}});
    end
  endfunction
  function [7:0] cmpx(input [31:0] v);
    integer b, n;
    begin
      for (b = 0; b < 8; b = b + 1) begin
        cmpx[b] = 1'b1;
        for (n = 0; n < 4; n = n + 1)
          if (rg[7][n] && v[8*n+b] != rg[2][n]) cmpx[b] = 1'b0;
      end
    end
  endfunction
  function hitx(input [1:0] m, input [19:0] ad);
    hitx = m == 2'h0 ? ad[19:17] == 3'h5 : m == 2'h1 ? ad[19:16] == 4'hA : m == 2'h2 ? ad[19:15] == 5'h16
      : ad[19:15] == 5'h17;
  endfunction
  initial begin
    #200000;
    errors = errors + 1;
    give_verdict;
  end
  initial begin
    {resetn, ioWrite, ioRead, ioIsData, memWrite, memRead, fourPlaneChaining} = 7'h00;
    {ioWData, hostWData, hostAddr} = 36'h0;
    planeWriteEnable = 4'hF;
    errors = 0;
    num_checks = 0;
    void'($urandom(32'hD7DF));
    repeat (16) @(negedge clk_sys);
    resetn = 1'b1;
    // ---------------------------------------------
    // reset values, window decode, preload
    // ---------------------------------------------
    for (i = 0; i < 9; i = i + 1) begin
      @(negedge clk_sys);
      ioIsData = 1'b0;
      ioWData = i;
      ioWrite = 1'b1;
      @(negedge clk_sys);
      ioWrite = 1'b0;
      ioIsData = 1'b1;
      rg[i] = i == 8 ? 8'hFF : 8'h00;
      #1 chk(ioRData, i == 8 ? 8'hFF : 8'h00);
    end
    for (k = 0; k < 4; k = k + 1) begin
      iow(4'h6, k << 2);
      for (i = 0; i < 8; i = i + 1) begin
        @(negedge clk_sys);
        hostAddr = WTAB[20*i +: 20];
        #1 chk(windowHit, hitx(k, hostAddr));
      end
    end
    iow(4'h6, 8'h05);
    iow(4'h3, 8'h00);
    for (a = 0; a < 16; a = a + 1) begin
      iow(4'h0, $urandom);
      iow(4'h1, $urandom);
      d = $urandom;
      sh[a] = wexp(32'h0, d);
      memwr(20'hA0000 + a, d, sh[a]);
    end
    // ---------------------------------------------
    // read then modify, every write mode
    // ---------------------------------------------
    for (k = 0; k < 64; k = k + 1) begin
      a = $urandom % 16;
      iow(4'h2, $urandom);
      iow(4'h7, $urandom);
      iow(4'h4, $urandom % 4);
      iow(4'h5, {4'h0, k[0], 3'h0});
      memrd(20'hA0000 + a);
      t = sh[a] >> {rg[4][1:0], 3'b000};
      chk(hostRData, rg[5][3] ? cmpx(sh[a]) : t[7:0]);
      iow(4'h0, $urandom);
      iow(4'h1, $urandom);
      iow(4'h3, $urandom % 32);
      iow(4'h5, {5'h0, k[3], k[2:1]});
      iow(4'h8, k < 4 ? 8'h00 : k < 8 ? 8'hFF : $urandom);
      iow(4'h6, {6'h1, 1'b0, k[4]});
      chk({pgdp_datapath_inst.graphicsMode, pgdp_datapath_inst.charLatchEnable}, {k[4], ~k[4]});
      planeWriteEnable = $urandom;
      pe = {{8{planeWriteEnable[3]}}, {8{planeWriteEnable[2]}}, {8{planeWriteEnable[1]}}, {8{planeWriteEnable[0]}}};
      d = $urandom;
      w = wexp(sh[a], d);
      memwr(20'hA0000 + a, d, w);
      sh[a] = (w & pe) | (sh[a] & ~pe);
    end
    // ---------------------------------------------
    // odd/even and chained plane pairs
    // ---------------------------------------------
    planeWriteEnable = 4'hF;
    iow(4'h5, 8'h10);
    chk(pgdp_datapath_inst.oddEvenMode, 1'b1);
    iow(4'h6, 8'h07);
    for (i = 0; i < 2; i = i + 1) begin
      @(negedge clk_sys);
      hostAddr = 20'hA0000 + i;
      memWrite = 1'b1;
      #1 chk(planeSelect, i ? 4'hA : 4'h5);
      @(negedge clk_sys);
      memWrite = 1'b0;
    end
    // ---------------------------------------------
    // four-plane chaining overrides the plane select
    // ---------------------------------------------
    iow(4'h6, 8'h05);
    iow(4'h5, 8'h64);
    chk({pgdp_datapath_inst.shiftInterleave, pgdp_datapath_inst.shift256,
      pgdp_datapath_inst.oddEvenMode}, 3'h6);
    iow(4'h4, 8'h03);
    @(negedge clk_sys);
    fourPlaneChaining = 1'b1;
    for (i = 4; i < 8; i = i + 1) begin
      memrd(20'hA0000 + i);
      t = sh[i] >> {i[1:0], 3'b000};
      chk(hostRData, t[7:0]);
    end
    give_verdict;
  end
endmodule
bind pgdp_datapath pgdp_sva pgdp_sva_inst (.clk_sys(clk_sys), .resetn(resetn), .ioWrite(ioWrite),
  .ioIsData(ioIsData), .ioWData(ioWData), .ioRData(ioRData), .hostAddr(hostAddr), .memWrite(memWrite),
  .memRead(memRead), .hostWData(hostWData), .hostRData(hostRData), .windowHit(windowHit),
  .fourPlaneChaining(fourPlaneChaining), .planeRData(planeRData), .planeWData(planeWData),
  .planeWrite(planeWrite), .graphicsMode(graphicsMode), .charLatchEnable(charLatchEnable),
  .oddEvenMode(oddEvenMode));
